// ---- rtl/fpc_pkg.sv ----
// Constants, layouts and carriers for the floppy/IDE power and mode config bank
package fpc_pkg;
	// Register indices on the index port
	localparam logic [7:0] IDX_UNIT_PWR   = 8'h06;
	localparam logic [7:0] IDX_DRV_TYPE   = 8'h07;
	localparam logic [7:0] IDX_DRV_CTRL   = 8'h08;
	localparam logic [7:0] IDX_MODE_LOCK  = 8'h09;
	localparam logic [7:0] IDX_PORT_POL   = 8'h0a;
	localparam logic [7:0] IDX_LOCK_LAST  = 8'h29;
	// Reset values
	localparam logic [3:0] RST_UNIT_PWR   = 4'h0;
	localparam logic [7:0] RST_DRV_TYPE   = 8'h00;
	localparam logic [7:0] RST_DRV_CTRL   = 8'h00;
	localparam logic [2:0] RST_MODE_BITS  = 3'h0;
	localparam logic [7:0] RST_PORT_POL   = 8'h1f;
	localparam logic [1:0] RST_TAPE       = 2'h0;
	// Arbitrary identification value, not tied to any part
	localparam logic [3:0] CHIP_ID        = 4'h5;
	// Power register fields
	localparam int B_FLOPPY_PD  = 3;
	localparam int B_DISK_PD    = 2;
	localparam int B_FLOPPY_TRI = 1;
	localparam int B_DISK_TRI   = 0;
	// Drive control fields
	localparam int B_APD_HI     = 7;
	localparam int B_APD_LO     = 6;
	localparam int B_WR_DIS     = 5;
	localparam int B_SW_WP      = 4;
	localparam int B_MEDIA_HI   = 3;
	localparam int B_BOOT_HI    = 1;
	// Mode register fields
	localparam int B_PMODE2     = 7;
	localparam int B_LOCK       = 6;
	localparam int B_THREE_MODE = 5;
	// Portable pin register fields
	localparam int B_PFE_POL    = 7;
	localparam int B_PXE_POL    = 6;
	localparam logic [7:0] PORT_POL_MASK = 8'hdf;
	localparam int B_DOCK_POL   = 4;
	localparam int B_PXE_ADP    = 3;
	localparam int B_PXE_EPP    = 2;
	localparam int B_PXE_ECP    = 1;
	localparam int B_PXE_ECPEPP = 0;
	// Tape drive register field position
	localparam int B_TAPE_LO    = 4;
	// Reduced write current codes
	localparam logic [1:0] RWC_NORMAL = 2'b00;
	localparam logic [1:0] RWC_LOW    = 2'b01;
	localparam logic [1:0] RWC_HIGH   = 2'b10;
	// Auto power-down countdown, seconds per code
	localparam logic [7:0] APD_SEC_0 = 8'd4;
	localparam logic [7:0] APD_SEC_1 = 8'd32;
	localparam logic [7:0] APD_SEC_2 = 8'd64;
	localparam logic [7:0] APD_SEC_3 = 8'd240;

	// Host access strobes on the index/data port pair
	typedef struct packed {
		logic       ext_mode;   // Extended-function mode active
		logic       index_wr;   // Write to index port
		logic       data_wr;    // Write to data port
		logic       data_rd;    // Read of data port
		logic       tape_wr;    // Write to tape drive register
		logic       tape_rd;    // Read of tape drive register
		logic [7:0] wdata;      // Write data
	} fpc_host_t;

	// Parallel port mode flags
	typedef struct packed {
		logic adapter;
		logic epp;
		logic ecp;
		logic ecp_epp;
	} fpc_pmode_t;
endpackage

// ---- rtl/fpc_cfg_regs.sv ----
// Floppy/IDE power, drive type and portable pin configuration register bank
`timescale 1ns/10ps
module fpc_cfg_regs (
	// Clock, reset, enable
	input  wire logic               core_clk,
	input  wire logic               reset_n,
	input  wire logic               clk_en,
	// Host index/data port access
	input  wire fpc_pkg::fpc_host_t host,
	output logic [7:0]              rd_data,
	// Power control to units
	output logic                    floppy_power_down,
	output logic                    disk_iface_power_down,
	output logic                    floppy_out_float,
	output logic                    disk_iface_out_float,
	output logic [7:0]              auto_pd_seconds,
	// Floppy controller side
	input  wire logic [1:0]         drive_sel,
	input  wire logic               rate_rwc_in,
	input  wire logic               fdc_write_en_n_in,
	input  wire logic               fdc_write_data_in,
	output logic                    reduced_write_current,
	output logic                    write_en_n,
	output logic                    write_serial_data,
	output logic                    write_protect_to_fdc,
	output logic [1:0]              media_id,
	output logic [1:0]              boot_drive,
	output logic                    three_mode_enable,
	// Drive pins
	input  wire logic               write_protect_pin_n,
	input  wire logic               dock_in,
	// Parallel port and portable pins
	input  wire logic [1:0]         port_mode_sel_lo,
	input  wire fpc_pkg::fpc_pmode_t pmode,
	input  wire logic               portable_floppy_act,
	output logic [2:0]              port_mode_sel,
	output logic                    portable_floppy_en,
	output logic                    portable_ext_en,
	output logic                    dock_active
);

	////////////////////////////////////////////////////////////////////////
	// Storage

	logic [7:0] index_ff;       // Selected register index
	logic [3:0] unit_pwr_ff;    // Power and tri-state bits
	logic [7:0] drv_type_ff;    // Four drive type fields
	logic [7:0] drv_ctrl_ff;    // Write control, countdown, media
	logic [2:0] mode_ff;        // Mode selector top, lock, three-mode
	logic [7:0] port_pol_ff;    // Portable pin polarity and enables
	logic [1:0] tape_ff;        // Tape register bits 5:4
	logic [7:0] rd_data_ff;     // Read data holding
	logic       rwc_ff;         // Reduced write current pin
	logic       we_n_ff;        // Write enable pin
	logic       wd_ff;          // Write data pin
	logic       wp_ff;          // Write protect to controller
	logic       pfe_ff;         // Portable floppy enable pin
	logic       pxe_ff;         // Portable extension enable pin
	logic       dock_ff;        // Docking indication
	logic [1:0] wp_sync_ff;     // Write protect synchroniser
	logic [1:0] dock_sync_ff;   // Dock input synchroniser

	////////////////////////////////////////////////////////////////////////
	// Decode

	// Lock covers every index up to 29h, including the mode register
	wire locked   = mode_ff[1] && (index_ff <= fpc_pkg::IDX_LOCK_LAST);
	wire acc_ok   = host.ext_mode && !locked;
	wire wr_ok    = acc_ok && host.data_wr;
	wire rd_ok    = acc_ok && host.data_rd;
	wire sel_pwr  = index_ff == fpc_pkg::IDX_UNIT_PWR;
	wire sel_type = index_ff == fpc_pkg::IDX_DRV_TYPE;
	wire sel_ctrl = index_ff == fpc_pkg::IDX_DRV_CTRL;
	wire sel_mode = index_ff == fpc_pkg::IDX_MODE_LOCK;
	wire sel_pol  = index_ff == fpc_pkg::IDX_PORT_POL;
	wire three_on = mode_ff[0];
	// Tape register only exists while three-mode is on
	wire tape_wr_ok = host.tape_wr && three_on;
	wire tape_rd_ok = host.tape_rd && three_on;

	// Read mux; reserved and out-of-scope bits read as zero
	wire [7:0] rd_pwr  = {4'h0, unit_pwr_ff};
	wire [7:0] rd_mode = {mode_ff, 1'b0, fpc_pkg::CHIP_ID};
	wire [7:0] rd_tape = {2'b00, tape_ff, 4'h0};
	wire [7:0] rd_sel  = sel_pwr  ? rd_pwr :
	                     sel_type ? drv_type_ff :
	                     sel_ctrl ? drv_ctrl_ff :
	                     sel_mode ? rd_mode :
	                     sel_pol  ? port_pol_ff : 8'h00;
	wire [7:0] nxt_rd_data = tape_rd_ok ? rd_tape :
	                         rd_ok      ? rd_sel  : rd_data_ff;

	////////////////////////////////////////////////////////////////////////
	// Drive behaviour

	// Type field of the drive now selected
	wire [1:0] drv_code = drv_type_ff[{drive_sel, 1'b0} +: 2];
	// A non-normal tape code outranks the per-drive type
	wire [1:0] eff_code = (tape_ff != fpc_pkg::RWC_NORMAL) ? tape_ff : drv_code;
	// Code 11 is don't-care; keep the rate level rather than float
	wire nxt_rwc = !three_on                     ? rate_rwc_in :
	               (eff_code == fpc_pkg::RWC_LOW)  ? 1'b0 :
	               (eff_code == fpc_pkg::RWC_HIGH) ? 1'b1 : rate_rwc_in;
	wire wr_dis = drv_ctrl_ff[fpc_pkg::B_WR_DIS];
	// Only the pins are forced; the controller itself never sees it
	wire nxt_we_n = wr_dis | fdc_write_en_n_in;
	wire nxt_wd   = wr_dis | fdc_write_data_in;
	wire nxt_wp   = drv_ctrl_ff[fpc_pkg::B_SW_WP] | !wp_sync_ff[1];

	////////////////////////////////////////////////////////////////////////
	// Portable pins

	wire pxe_act = (pmode.adapter && port_pol_ff[fpc_pkg::B_PXE_ADP]) ||
	               (pmode.epp     && port_pol_ff[fpc_pkg::B_PXE_EPP]) ||
	               (pmode.ecp     && port_pol_ff[fpc_pkg::B_PXE_ECP]) ||
	               (pmode.ecp_epp && port_pol_ff[fpc_pkg::B_PXE_ECPEPP]);
	// Polarity bit one means the pin is high when active
	wire nxt_pfe  = !(portable_floppy_act ^ port_pol_ff[fpc_pkg::B_PFE_POL]);
	wire nxt_pxe  = !(pxe_act ^ port_pol_ff[fpc_pkg::B_PXE_POL]);
	wire nxt_dock = !(dock_sync_ff[1] ^ port_pol_ff[fpc_pkg::B_DOCK_POL]);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage feeds only the second

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_sync_ff   <= 2'b11;
			dock_sync_ff <= 2'b00;
		end else if (clk_en) begin
			wp_sync_ff   <= {wp_sync_ff[0], write_protect_pin_n};
			dock_sync_ff <= {dock_sync_ff[0], dock_in};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Index register, written only in extended mode

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			index_ff <= 8'h00;
		end else if (clk_en && host.ext_mode && host.index_wr) begin
			index_ff <= host.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			unit_pwr_ff <= fpc_pkg::RST_UNIT_PWR;
			drv_type_ff <= fpc_pkg::RST_DRV_TYPE;
			drv_ctrl_ff <= fpc_pkg::RST_DRV_CTRL;
			mode_ff     <= fpc_pkg::RST_MODE_BITS;
			port_pol_ff <= fpc_pkg::RST_PORT_POL;
		end else if (clk_en && wr_ok) begin
			// Only implemented bits are stored
			if (sel_pwr) begin
				unit_pwr_ff <= host.wdata[3:0];
			end
			if (sel_type) begin
				drv_type_ff <= host.wdata;
			end
			if (sel_ctrl) begin
				drv_ctrl_ff <= host.wdata;
			end
			if (sel_mode) begin
				mode_ff <= host.wdata[7:5];
			end
			if (sel_pol) begin
				port_pol_ff <= host.wdata & fpc_pkg::PORT_POL_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tape drive register and read data

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tape_ff    <= fpc_pkg::RST_TAPE;
			rd_data_ff <= 8'h00;
		end else if (clk_en) begin
			if (tape_wr_ok) begin
				tape_ff <= host.wdata[fpc_pkg::B_TAPE_LO +: 2];
			end
			rd_data_ff <= nxt_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered pin outputs

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rwc_ff  <= 1'b0;
			we_n_ff <= 1'b1;
			wd_ff   <= 1'b1;
			wp_ff   <= 1'b0;
			pfe_ff  <= 1'b1;
			pxe_ff  <= 1'b1;
			dock_ff <= 1'b0;
		end else if (clk_en) begin
			rwc_ff  <= nxt_rwc;
			we_n_ff <= nxt_we_n;
			wd_ff   <= nxt_wd;
			wp_ff   <= nxt_wp;
			pfe_ff  <= nxt_pfe;
			pxe_ff  <= nxt_pxe;
			dock_ff <= nxt_dock;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Floating needs both power-down and its tri-state enable
	assign floppy_power_down     = unit_pwr_ff[fpc_pkg::B_FLOPPY_PD];
	assign disk_iface_power_down = unit_pwr_ff[fpc_pkg::B_DISK_PD];
	assign floppy_out_float      = floppy_power_down &&
	                               unit_pwr_ff[fpc_pkg::B_FLOPPY_TRI];
	assign disk_iface_out_float  = disk_iface_power_down &&
	                               unit_pwr_ff[fpc_pkg::B_DISK_TRI];
	wire [1:0] apd_code = drv_ctrl_ff[fpc_pkg::B_APD_HI -: 2];
	assign auto_pd_seconds = (apd_code == 2'b00) ? fpc_pkg::APD_SEC_0 :
	                         (apd_code == 2'b01) ? fpc_pkg::APD_SEC_1 :
	                         (apd_code == 2'b10) ? fpc_pkg::APD_SEC_2 :
	                                               fpc_pkg::APD_SEC_3;
	assign media_id          = drv_ctrl_ff[fpc_pkg::B_MEDIA_HI -: 2];
	assign boot_drive        = drv_ctrl_ff[fpc_pkg::B_BOOT_HI -: 2];
	assign three_mode_enable = three_on;
	assign port_mode_sel     = {mode_ff[2], port_mode_sel_lo};
	assign rd_data               = rd_data_ff;
	assign reduced_write_current = rwc_ff;
	assign write_en_n            = we_n_ff;
	assign write_serial_data     = wd_ff;
	assign write_protect_to_fdc  = wp_ff;
	assign portable_floppy_en    = pfe_ff;
	assign portable_ext_en       = pxe_ff;
	assign dock_active           = dock_ff;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// Index write then data read of the mode register
	sequence s_idx_mode;
		clk_en && host.ext_mode && host.index_wr &&
			host.wdata == fpc_pkg::IDX_MODE_LOCK;
	endsequence
	sequence s_read_now;
		clk_en && host.ext_mode && host.data_rd && !host.tape_rd && !mode_ff[1];
	endsequence

	a_chip_id_read: assert property (s_idx_mode ##1 s_read_now |=>
		rd_data[3:0] == fpc_pkg::CHIP_ID && rd_data[4] == 1'b0)
		else $error("chip id read wrong");
	a_lock_blocks_wr: assert property (clk_en && locked && host.data_wr |=>
		$stable(drv_type_ff) && $stable(drv_ctrl_ff) && $stable(port_pol_ff))
		else $error("locked register changed");
	a_no_ext_no_wr: assert property (clk_en && !host.ext_mode |=>
		$stable(index_ff) && $stable(unit_pwr_ff) && $stable(mode_ff))
		else $error("access outside extended mode");
	a_wr_dis_pins: assert property (clk_en && wr_dis |=>
		write_en_n && write_serial_data)
		else $error("write pins not held high");
	a_software_write_protect_protects: assert property (clk_en && drv_ctrl_ff[fpc_pkg::B_SW_WP] |=>
		write_protect_to_fdc)
		else $error("software protect not reported");
	a_tape_gated: assert property (clk_en && host.tape_wr && !three_on |=>
		$stable(tape_ff))
		else $error("tape register written while off");
	a_rwc_low_code: assert property (clk_en && three_on && eff_code == fpc_pkg::RWC_LOW |=>
		!reduced_write_current)
		else $error("reduced current not low");
	a_rwc_normal: assert property (clk_en && !three_on |=>
		reduced_write_current == $past(rate_rwc_in))
		else $error("normal rate level not passed");
	// Float must follow the written power and tri-state bits, not just the flops
	a_float_needs_pd: assert property (clk_en && wr_ok && sel_pwr |=>
		floppy_out_float == ($past(host.wdata[fpc_pkg::B_FLOPPY_PD]) &&
		$past(host.wdata[fpc_pkg::B_FLOPPY_TRI])))
		else $error("floppy float does not follow power bits");
	a_pol_reserved: assert property (clk_en && rd_ok && !tape_rd_ok && sel_pol |=>
		rd_data[5] == 1'b0 && port_pol_ff[5] == 1'b0)
		else $error("reserved bit set");

endmodule

// ---- tb/fpc_drive_model.sv ----
// Behavioural drive and portable pin model facing the config bank
`timescale 1ns/10ps
module fpc_drive_model (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	// Write pins from the device
	input  wire logic write_en_n,
	input  wire logic write_serial_data,
	// Media state set by the bench
	input  wire logic wp_tab,
	input  wire logic dock_level,
	// Pins back into the device
	output logic      write_protect_pin_n,
	output logic      dock_in,
	// Count of bits that reached the media
	output int        n_wr_bits
);
	////////////////////////////////////////////////////////////////
	// Write-protect tab pulls the pin low, dock line follows the cable
	assign write_protect_pin_n = ~wp_tab;
	assign dock_in             = dock_level;

	////////////////////////////////////////////////////////////////
	// Head writes only when both strobes sit low in one cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			n_wr_bits <= 0;
		end else if (!write_en_n && !write_serial_data) begin
			n_wr_bits <= n_wr_bits + 1;
		end
	end
endmodule

// ---- tb/fpc_cfg_regs_bench.sv ----
// Self-checking bench for the floppy/IDE power and mode config bank
`timescale 1ns/10ps
module fpc_cfg_regs_bench;
	// Clock, reset and host side
	logic               core_clk, reset_n, clk_en;
	fpc_pkg::fpc_host_t host;
	fpc_pkg::fpc_pmode_t pmode;
	logic [7:0]         rd_data, auto_pd_seconds, held;
	// Unit and drive side
	logic [1:0]         drive_sel, media_id, boot_drive, port_mode_sel_lo;
	logic [2:0]         port_mode_sel;
	logic               floppy_power_down, disk_iface_power_down;
	logic               floppy_out_float, disk_iface_out_float;
	logic               rate_rwc_in, fdc_write_en_n_in, fdc_write_data_in;
	logic               reduced_write_current, write_en_n, write_serial_data;
	logic               write_protect_to_fdc, three_mode_enable, portable_floppy_act;
	logic               portable_floppy_en, portable_ext_en, dock_active;
	logic               write_protect_pin_n, dock_in, wp_tab, dock_level;
	// Bookkeeping
	int                 n_wr_bits, n_mismatch, n_tests, cyc, snap;
	logic [7:0]         idx[4] = '{8'h06, 8'h07, 8'h08, 8'h0a};
	logic [7:0]         msk[4] = '{8'h0f, 8'hff, 8'hff, 8'hdf};
	logic [7:0]         apd[4] = '{8'd4, 8'd32, 8'd64, 8'd240};

	fpc_cfg_regs u_fpc_cfg_regs (.core_clk, .reset_n, .clk_en, .host, .rd_data,
		.floppy_power_down, .disk_iface_power_down, .floppy_out_float,
		.disk_iface_out_float, .auto_pd_seconds, .drive_sel, .rate_rwc_in,
		.fdc_write_en_n_in, .fdc_write_data_in, .reduced_write_current, .write_en_n,
		.write_serial_data, .write_protect_to_fdc, .media_id, .boot_drive,
		.three_mode_enable, .write_protect_pin_n, .dock_in, .port_mode_sel_lo, .pmode,
		.portable_floppy_act, .port_mode_sel, .portable_floppy_en, .portable_ext_en,
		.dock_active);
	fpc_drive_model u_fpc_drive_model (.core_clk, .reset_n, .write_en_n,
		.write_serial_data, .wp_tab, .dock_level, .write_protect_pin_n, .dock_in,
		.n_wr_bits);

	////////////////////////////////////////////////////////////////
	// 250 MHz clock and a hang guard well past the expected run
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////
	// Shared tasks; inputs always move 1 ns after the edge
	task automatic step(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		host.index_wr = 1'b1;
		host.wdata = a;
		step(1);
		host.index_wr = 1'b0;
		host.data_wr = 1'b1;
		host.wdata = d;
		step(1);
		host.data_wr = 1'b0;
	endtask
	// Read answer lands one edge after the strobe; one spare edge taken
	task automatic rd(logic [7:0] a, string what, logic [7:0] exp);
		host.index_wr = 1'b1;
		host.wdata = a;
		step(1);
		host.index_wr = 1'b0;
		host.data_rd = 1'b1;
		step(1);
		host.data_rd = 1'b0;
		step(1);
		chk(what, rd_data, exp);
	endtask
	task automatic tape(logic w, logic [7:0] d);
		host.tape_wr = w;
		host.tape_rd = !w;
		host.wdata = d;
		step(1);
		host.tape_wr = 1'b0;
		host.tape_rd = 1'b0;
		step(1);
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{n_mismatch, n_tests, cyc} = '0;
		host = '0;
		host.ext_mode = 1'b1;
		{reset_n, clk_en, pmode, drive_sel, port_mode_sel_lo, rate_rwc_in} = '0;
		{portable_floppy_act, wp_tab, dock_level} = '0;
		{fdc_write_en_n_in, fdc_write_data_in} = 2'b11;
		step(5);
		reset_n = 1'b1;
		clk_en = 1'b1;
		step(2);
		chk("reset pins", 8'({write_en_n, write_serial_data, portable_floppy_en, portable_ext_en}),
			8'h0f);
		for (int i = 0; i < 4; i++) rd(idx[i], "reset value", i == 3 ? 8'h1f : 8'h00);
		rd(8'h09, "mode reset", {4'h0, fpc_pkg::CHIP_ID});
		for (int i = 0; i < 4; i++) begin
			wr(idx[i], 8'hff);
			rd(idx[i], "reserved bits", msk[i]);
			wr(idx[i], 8'h00);
		end
		// Every power/float combination
		for (int i = 0; i < 16; i++) begin
			wr(8'h06, 8'(i));
			step(1);
			chk("power pins", {floppy_power_down, disk_iface_power_down, floppy_out_float,
				disk_iface_out_float}, 8'({i[3], i[2], i[3] & i[1], i[2] & i[0]}));
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h08, 8'(i << 6));
			step(1);
			chk("auto pd time", auto_pd_seconds, apd[i]);
		end
		// Write disable against a controller that keeps writing
		{fdc_write_en_n_in, fdc_write_data_in} = 2'b00;
		wr(8'h08, 8'h20);
		step(2);
		snap = n_wr_bits;
		chk("write pins", 8'({write_en_n, write_serial_data}), 8'h03);
		step(10);
		chk("media writes", 8'(n_wr_bits - snap), 8'h00);
		rd(8'h08, "ctrl readback", 8'h20);
		wr(8'h08, 8'h00);
		step(2);
		chk("write pass", 8'({write_en_n, write_serial_data}), 8'h00);
		{fdc_write_en_n_in, fdc_write_data_in} = 2'b11;
		wp_tab = 1'b1;
		step(4);
		chk("wp pin", 8'(write_protect_to_fdc), 8'h01);
		wp_tab = 1'b0;
		wr(8'h08, 8'h1f);
		step(4);
		chk("sw protect", 8'(write_protect_to_fdc), 8'h01);
		chk("media boot", 8'({media_id, boot_drive}), 8'h0f);
		wr(8'h08, 8'h00);
		step(2);
		chk("wp clear", 8'(write_protect_to_fdc), 8'h00);
		// Drive type codes per drive with three-mode on
		wr(8'h09, 8'h20);
		chk("3mode", 8'(three_mode_enable), 8'h01);
		for (int d = 0; d < 4; d++)
			for (int c = 0; c < 4; c++)
				for (int r = 0; r < 2; r++) begin
					wr(8'h07, 8'(c << (2 * d)));
					drive_sel = 2'(d);
					rate_rwc_in = r[0];
					step(2);
					chk("rwc type", 8'(reduced_write_current),
						8'(c == 1 ? 0 : c == 2 ? 1 : r));
				end
		wr(8'h07, 8'h00);
		drive_sel = 2'd0;
		rate_rwc_in = 1'b1;
		tape(1'b1, 8'h10);
		step(1);
		chk("tape low", 8'(reduced_write_current), 8'h00);
		tape(1'b1, 8'hff);
		tape(1'b0, 8'h00);
		chk("tape read", rd_data, 8'h30);
		chk("tape dc", 8'(reduced_write_current), 8'h01);
		rate_rwc_in = 1'b0;
		tape(1'b1, 8'h20);
		step(1);
		chk("tape high", 8'(reduced_write_current), 8'h01);
		tape(1'b1, 8'h00);
		// Three-mode off: tape access refused, type codes unused
		wr(8'h09, 8'h00);
		wr(8'h07, 8'h01);
		rate_rwc_in = 1'b1;
		tape(1'b1, 8'h10);
		step(1);
		chk("no 3mode", 8'(reduced_write_current), 8'h01);
		held = rd_data;
		tape(1'b0, 8'h00);
		chk("tape gated", rd_data, held);
		wr(8'h09, 8'h20);
		tape(1'b0, 8'h00);
		chk("tape kept", rd_data, 8'h00);
		wr(8'h09, 8'h9f);
		port_mode_sel_lo = 2'b01;
		step(1);
		chk("port mode", 8'(port_mode_sel), 8'h05);
		rd(8'h09, "mode read", {4'h8, fpc_pkg::CHIP_ID});
		// Portable pins across polarities and modes
		for (int p = 0; p < 2; p++) begin
			for (int a = 0; a < 2; a++) begin
				wr(8'h0a, 8'(p << 7));
				portable_floppy_act = a[0];
				dock_level = a[0];
				wr(8'h0a, 8'(p << 7 | p << 4));
				step(4);
				chk("floppy en", 8'(portable_floppy_en), 8'(p == a ? 1 : 0));
				chk("dock", 8'(dock_active), 8'(p == a ? 1 : 0));
			end
			for (int b = 0; b < 4; b++)
				for (int m = 0; m < 4; m++) begin
					wr(8'h0a, 8'(p << 6 | 1 << b));
					pmode = 4'(1 << m);
					step(2);
					chk("ext en", 8'(portable_ext_en), 8'((m == b) == p));
				end
		end
		// Access gating: extended mode, clock enable, lock
		rd(8'h07, "type", 8'h01);
		host.ext_mode = 1'b0;
		wr(8'h07, 8'h55);
		rd(8'h0a, "no ext read", 8'h01);
		host.ext_mode = 1'b1;
		clk_en = 1'b0;
		wr(8'h07, 8'h33);
		clk_en = 1'b1;
		rd(8'h07, "no ext write", 8'h01);
		rd(8'h30, "unmapped", 8'h00);
		rd(8'h0a, "pol", 8'h48);
		wr(8'h09, 8'h40);
		wr(8'h07, 8'h77);
		rd(8'h07, "locked", 8'h48);
		rd(8'h30, "above lock", 8'h00);
		reset_n = 1'b0;
		step(2);
		reset_n = 1'b1;
		rd(8'h07, "type reset", 8'h00);
		rd(8'h09, "unlocked", {4'h0, fpc_pkg::CHIP_ID});
		close_out();
	end
endmodule
